/* design/rbcg_pkg.sv */
// package: constants for reset, boot mode and clock generation block
package rbcg_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_WAKEUP = 8'h00;
  localparam logic [7:0] OFF_CLOCK = 8'h04;
  localparam logic [7:0] OFF_SYSCTL1 = 8'h08;
  localparam logic [7:0] OFF_UNLOCK = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // field positions
  localparam int WK_BROWNOUT_BIT = 0;
  localparam int WK_BRN_EN_BIT = 1;
  localparam int CK_RELOAD_LSB = 0;
  localparam int CK_SLOW_BIT = 5;
  localparam int CK_KDIV_LSB = 6;
  localparam int SC_SWAP_BIT = 0;
  localparam int SC_BOOTEN_BIT = 1;

  // reset values
  localparam logic [8:0] CLOCK_RST = 9'h01f;
  localparam logic [1:0] WAKEUP_RST = 2'h2;
  localparam logic [1:0] SYSCTL1_RST = 2'h0;

  // unlock sequence bytes
  localparam logic [7:0] UNLOCK_KEY1 = 8'haa;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h55;

  // brownout release hold in pll clocks
  localparam int BRN_RELEASE_CLKS = 4096;
  // brownout detect time in ns, figure not yet fixed
  localparam int BRN_DETECT_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int BRN_DETECT_CLKS = (BRN_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // vco multiplier
  localparam int VCO_MULT = 15;

  // irq event bits
  localparam int IRQ_BROWNOUT = 0;
  localparam int IRQ_MODE_SW = 1;
  localparam int IRQ_LOCK = 2;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_BOOT,
    MODE_TEST,
    MODE_XRAM
  } rbcg_mode_t;

endpackage : rbcg_pkg

/* design/rbcg_clkdiv.sv */
// module: slowdown divider producing a clock-enable pulse
`timescale 1ns/1ps
module rbcg_clkdiv #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic [W-1:0] reload,
  // output tick
  output logic tick
);

  logic [W-1:0] cnt_ff;

  // divide by reload+1, from 1 to 32
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
    end
    else if (cnt_ff >= reload)
    begin
      cnt_ff <= '0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign tick = (cnt_ff >= reload);

endmodule : rbcg_clkdiv

/* design/rbcg_top.sv */
// module: reset, boot mode select, brownout and clock divider control
// Behaviour
// - reset low active, hold until pll lock
// - reset rise: boot pin high normal, low bootstrap
// - transmit low with boot low gives test
// - software bootstrap: enable set, swap clear, unlock
// - brownout continuous for detect time resets
// - release brownout after 4096 locked clocks
// - brownout flag set, cleared by reset or write
// - ports tristate during brownout
// - slowdown divides by 1 to 32
// - slowdown selects divider output as clock
// - vco fifteen times oscillator, divided by k
// - k select code table
// - swap set selects xram modes
// - hardware reset aborts software mode change
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module rbcg_top #(
  parameter int BRN_RELEASE = rbcg_pkg::BRN_RELEASE_CLKS,
  parameter int BRN_DETECT = rbcg_pkg::BRN_DETECT_CLKS
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and analog indications
  input wire logic reset_n_pin,
  input wire logic boot_select_pin,
  input wire logic txd_pin,
  input wire logic pll_lock,
  input wire logic core_supply_low,
  // outputs
  output logic core_reset_n,
  output logic port_tristate,
  output logic [1:0] chip_mode,
  output logic [4:0] k_factor,
  output logic sysclk_en,
  output logic slowdown_active,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // k factor lookup

  function automatic logic [4:0] kdiv_factor(input logic [2:0] code);
    case (code)
      3'h0: kdiv_factor = 5'h02;
      3'h1: kdiv_factor = 5'h10;
      3'h2: kdiv_factor = 5'h04;
      3'h3: kdiv_factor = 5'h05;
      3'h4: kdiv_factor = 5'h06;
      3'h5: kdiv_factor = 5'h08;
      3'h6: kdiv_factor = 5'h09;
      default: kdiv_factor = 5'h0a;
    endcase
  endfunction : kdiv_factor

  ////////////////////////////////////////////////////////////////////////////
  // pin reset synchroniser

  logic rst_s1_ff;
  logic rst_s2_ff;
  logic rst_prev_ff;
  logic rst_rise;

  // pin sampled synchronously, filtered through two stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
      rst_prev_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= reset_n_pin;
      rst_s2_ff <= rst_s1_ff;
      rst_prev_ff <= rst_s2_ff;
    end
  end

  assign rst_rise = rst_s2_ff && !rst_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // brownout detection and release

  logic [15:0] brn_cnt_ff;
  logic brn_active_ff;
  logic [15:0] lock_cnt_ff;
  logic brn_event;
  logic brn_en_ff;

  assign brn_event = rst_s2_ff && core_supply_low && brn_en_ff
                     && (brn_cnt_ff == 16'(BRN_DETECT - 1)) && !brn_active_ff;

  // detection time counter while reset pin high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brn_cnt_ff <= '0;
    end
    else if (!rst_s2_ff || !core_supply_low)
    begin
      brn_cnt_ff <= '0;
    end
    else if (brn_cnt_ff != 16'(BRN_DETECT - 1))
    begin
      brn_cnt_ff <= brn_cnt_ff + 16'h0001;
    end
  end

  // brownout reset state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brn_active_ff <= 1'b0;
    end
    else if (!rst_s2_ff)
    begin
      brn_active_ff <= 1'b0;
    end
    else if (brn_event)
    begin
      brn_active_ff <= 1'b1;
    end
    else if (!core_supply_low && pll_lock && lock_cnt_ff == 16'(BRN_RELEASE - 1))
    begin
      brn_active_ff <= 1'b0;
    end
  end

  // locked clock count after supply recovery
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_cnt_ff <= '0;
    end
    else if (!brn_active_ff || core_supply_low || !pll_lock)
    begin
      lock_cnt_ff <= '0;
    end
    else
    begin
      lock_cnt_ff <= lock_cnt_ff + 16'h0001;
    end
  end

  assign port_tristate = brn_active_ff;

  ////////////////////////////////////////////////////////////////////////////
  // core reset, synchronous release

  logic core_rst_n_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_rst_n_ff <= 1'b0;
    end
    else
    begin
      core_rst_n_ff <= rst_s2_ff && pll_lock && !brn_active_ff;
    end
  end

  assign core_reset_n = core_rst_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic wr_en;
  logic rd_en;
  logic [8:0] clock_ff;
  logic brn_flag_ff;
  logic [1:0] sysctl1_ff;
  logic [1:0] unlock_st_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic sw_unlock;
  logic lock_prev_ff;
  rbcg_pkg::rbcg_mode_t mode_ff;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign sw_unlock = wr_en && paddr == rbcg_pkg::OFF_UNLOCK
                     && unlock_st_ff == 2'h1 && pwdata[7:0] == rbcg_pkg::UNLOCK_KEY2;

  // clock control and system control 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_ff <= rbcg_pkg::CLOCK_RST;
      sysctl1_ff <= rbcg_pkg::SYSCTL1_RST;
      brn_en_ff <= rbcg_pkg::WAKEUP_RST[rbcg_pkg::WK_BRN_EN_BIT];
    end
    else if (wr_en && paddr == rbcg_pkg::OFF_CLOCK)
    begin
      clock_ff <= pwdata[8:0];
    end
    else if (wr_en && paddr == rbcg_pkg::OFF_SYSCTL1)
    begin
      sysctl1_ff <= pwdata[1:0];
    end
    else if (wr_en && paddr == rbcg_pkg::OFF_WAKEUP)
    begin
      brn_en_ff <= pwdata[rbcg_pkg::WK_BRN_EN_BIT];
    end
  end

  // brownout flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brn_flag_ff <= 1'b0;
    end
    else if (brn_event)
    begin
      brn_flag_ff <= 1'b1;
    end
    else if (wr_en && paddr == rbcg_pkg::OFF_WAKEUP && !pwdata[rbcg_pkg::WK_BROWNOUT_BIT])
    begin
      brn_flag_ff <= 1'b0;
    end
  end

  // unlock sequence tracker, aborted by pin reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unlock_st_ff <= 2'h0;
    end
    else if (!rst_s2_ff)
    begin
      unlock_st_ff <= 2'h0;
    end
    else if (wr_en && paddr == rbcg_pkg::OFF_UNLOCK)
    begin
      unlock_st_ff <= (pwdata[7:0] == rbcg_pkg::UNLOCK_KEY1) ? 2'h1 : 2'h0;
    end
    else if (wr_en)
    begin
      unlock_st_ff <= 2'h0;
    end
  end

  // chip mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= rbcg_pkg::MODE_NORMAL;
    end
    else if (rst_rise)
    begin
      if (boot_select_pin)
      begin
        mode_ff <= rbcg_pkg::MODE_NORMAL;
      end
      else if (!txd_pin)
      begin
        mode_ff <= rbcg_pkg::MODE_TEST;
      end
      else
      begin
        mode_ff <= rbcg_pkg::MODE_BOOT;
      end
    end
    else if (sw_unlock && rst_s2_ff)
    begin
      case (sysctl1_ff)
        2'h0: mode_ff <= rbcg_pkg::MODE_NORMAL;
        2'h2: mode_ff <= rbcg_pkg::MODE_BOOT;
        2'h1: mode_ff <= rbcg_pkg::MODE_XRAM;
        default: mode_ff <= rbcg_pkg::MODE_XRAM;
      endcase
    end
  end

  assign chip_mode = mode_ff;

  // interrupt status, read clears, set wins
  logic [2:0] irq_set;
  assign irq_set = {pll_lock && !lock_prev_ff, sw_unlock, brn_event};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      lock_prev_ff <= 1'b0;
    end
    else
    begin
      lock_prev_ff <= pll_lock;
      if (rd_en && paddr == rbcg_pkg::OFF_IRQ_STAT)
      begin
        irq_stat_ff <= irq_set;
      end
      else
      begin
        irq_stat_ff <= irq_stat_ff | irq_set;
      end
      if (wr_en && paddr == rbcg_pkg::OFF_IRQ_MASK)
      begin
        irq_mask_ff <= pwdata[2:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // read data
  always_comb
  begin
    prdata = 32'h0;
    case (paddr)
      rbcg_pkg::OFF_WAKEUP: prdata = {30'h0, brn_en_ff, brn_flag_ff};
      rbcg_pkg::OFF_CLOCK: prdata = {23'h0, clock_ff};
      rbcg_pkg::OFF_SYSCTL1: prdata = {30'h0, sysctl1_ff};
      rbcg_pkg::OFF_STATUS: prdata = {24'h0, 1'b0, k_factor, chip_mode};
      rbcg_pkg::OFF_IRQ_STAT: prdata = {29'h0, irq_stat_ff};
      rbcg_pkg::OFF_IRQ_MASK: prdata = {29'h0, irq_mask_ff};
      default: prdata = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock selection

  logic slow_tick;
  logic [4:0] k_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      k_ff <= 5'h02;
    end
    else
    begin
      k_ff <= kdiv_factor(clock_ff[8:6]);
    end
  end

  assign k_factor = k_ff;

  rbcg_clkdiv #(
    .W(5)
  ) u_slowdiv (
    .pclk(pclk),
    .presetn(presetn),
    .reload(clock_ff[4:0]),
    .tick(slow_tick)
  );

  assign slowdown_active = clock_ff[rbcg_pkg::CK_SLOW_BIT];
  assign sysclk_en = slowdown_active ? slow_tick : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  brn_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(brn_active_ff) && rst_s2_ff |-> $past(lock_cnt_ff) == 16'(BRN_RELEASE - 1))
    else $error("brownout released early");

  core_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pll_lock |=> !core_reset_n)
    else $error("core left reset without lock");

  tristate_a: assert property (@(posedge pclk) disable iff (!presetn)
    brn_event |=> port_tristate ##1 !core_reset_n)
    else $error("ports driven in brownout");

  brn_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    brn_event |=> brn_flag_ff)
    else $error("brownout flag not set");

  boot_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_rise && !boot_select_pin && txd_pin |=> chip_mode == rbcg_pkg::MODE_BOOT)
    else $error("bootstrap mode not entered");

  test_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_rise && !boot_select_pin && !txd_pin |=> chip_mode == rbcg_pkg::MODE_TEST)
    else $error("test mode not entered");

  slow_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    !slowdown_active |-> sysclk_en)
    else $error("pll clock not selected");

  unlock_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rst_s2_ff |=> unlock_st_ff == 2'h0)
    else $error("unlock survived reset");

endmodule : rbcg_top

/* bench/rbcg_partner.sv */
// far-side model: reset pin, mode straps, pll lock and supply detector
`timescale 1ns/1ps
module rbcg_partner #(
  parameter int LOCK_DLY = 12
) (
  // clock
  input wire logic pclk,
  // commands from the bench
  input wire logic cmd_rst,
  input wire logic cmd_boot,
  input wire logic cmd_txd_low,
  input wire logic cmd_dip,
  // pins
  output logic reset_n_pin,
  output logic boot_select_pin,
  output logic txd_pin,
  output logic pll_lock,
  output logic core_supply_low
);
  int cnt_ff = 0;
  assign reset_n_pin = !cmd_rst;
  assign boot_select_pin = cmd_boot;
  // pulled high unless a test-mode strap is commanded
  assign txd_pin = !cmd_txd_low;
  assign core_supply_low = cmd_dip;
  // lock comes slowly after each pin reset
  // models an 8 MHz oscillator, vco at 120 MHz inside its band
  assign pll_lock = (cnt_ff >= LOCK_DLY);
  always_ff @(posedge pclk)
  begin
    if (cmd_rst)
      cnt_ff <= 0;
    else if (cnt_ff < LOCK_DLY)
      cnt_ff <= cnt_ff + 1;
  end
endmodule : rbcg_partner

/* bench/rbcg_top_tb.sv */
// self-checking bench for the reset, boot mode and clock block
`timescale 1ns/1ps
module rbcg_top_tb;
  typedef struct {logic b; logic t; logic [2:0] c; logic [1:0] m; logic [4:0] k;} rbcg_row_t;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, reset_n_pin, boot_select_pin, txd_pin, pll_lock, core_supply_low;
  logic cmd_rst = 1'h1;
  logic cmd_boot = 1'h1;
  logic cmd_txd_low = 1'h0;
  logic cmd_dip = 1'h0;
  logic core_reset_n, port_tristate, sysclk_en, slowdown_active, irq;
  logic [1:0] chip_mode;
  logic [4:0] k_factor;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  rbcg_row_t rows[8] = '{'{1'h1, 1'h0, 3'h0, 2'h0, 5'h02}, '{1'h0, 1'h0, 3'h1, 2'h1, 5'h10},
    '{1'h0, 1'h1, 3'h2, 2'h2, 5'h04}, '{1'h1, 1'h1, 3'h3, 2'h0, 5'h05},
    '{1'h1, 1'h0, 3'h4, 2'h0, 5'h06}, '{1'h0, 1'h0, 3'h5, 2'h1, 5'h08},
    '{1'h0, 1'h1, 3'h6, 2'h2, 5'h09}, '{1'h1, 1'h1, 3'h7, 2'h0, 5'h0a}};
  logic [3:0] sw[4] = '{4'h9, 4'hf, 4'h7, 4'h0};

  rbcg_top #(.BRN_RELEASE(16), .BRN_DETECT(8)) i_rbcg_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_n_pin, .boot_select_pin,
    .txd_pin, .pll_lock, .core_supply_low, .core_reset_n, .port_tristate, .chip_mode,
    .k_factor, .sysclk_en, .slowdown_active, .irq);
  rbcg_partner #(.LOCK_DLY(12)) i_rbcg_partner (.pclk, .cmd_rst, .cmd_boot, .cmd_txd_low,
    .cmd_dip, .reset_n_pin, .boot_select_pin, .txd_pin, .pll_lock, .core_supply_low);

  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task pin_reset(input logic b, input logic t);
    cmd_rst <= 1'h1;
    cmd_boot <= b;
    cmd_txd_low <= t;
    repeat (4) @(posedge pclk);
    cmd_rst <= 1'h0;
    for (n = 0; n < 50 && pll_lock !== 1'h1; n++)
      @(negedge pclk);
    chk("core held before lock", {31'h0, core_reset_n}, 32'h0);
    for (n = 0; n < 20 && core_reset_n !== 1'h1; n++)
      @(negedge pclk);
    chk("core released", {31'h0, core_reset_n}, 32'h1);
    @(posedge pclk);
    cmd_txd_low <= 1'h0;
  endtask : pin_reset
  task cnt_en(input int c);
    repeat (40) @(posedge pclk);
    n = 0;
    repeat (c)
    begin
      @(negedge pclk);
      if (sysclk_en === 1'h1)
        n++;
    end
    @(posedge pclk);
  endtask : cnt_en
  task unlock(input logic [1:0] v);
    apb(1'h1, rbcg_pkg::OFF_SYSCTL1, {30'h0, v});
    apb(1'h1, rbcg_pkg::OFF_UNLOCK, {24'h0, rbcg_pkg::UNLOCK_KEY1});
    apb(1'h1, rbcg_pkg::OFF_UNLOCK, {24'h0, rbcg_pkg::UNLOCK_KEY2});
    repeat (2) @(posedge pclk);
  endtask : unlock
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("reset outs", {core_reset_n, port_tristate, chip_mode, k_factor, irq}, 32'h4);
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, rbcg_pkg::OFF_WAKEUP, 32'h0);
    chk("wakeup rst", rd, {30'h0, rbcg_pkg::WAKEUP_RST});
    apb(1'h0, rbcg_pkg::OFF_CLOCK, 32'h0);
    chk("clock rst", rd, {23'h0, rbcg_pkg::CLOCK_RST});
    apb(1'h1, 8'h1c, 32'hffffffff);
    apb(1'h0, 8'h1c, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("no error", {31'h0, pslverr}, 32'h0);
    // straps at reset rise and every divider code, read back and checked at the pins
    foreach (rows[i])
    begin
      pin_reset(rows[i].b, rows[i].t);
      apb(1'h1, rbcg_pkg::OFF_CLOCK, {23'h0, rows[i].c, 6'h1f});
      apb(1'h0, rbcg_pkg::OFF_STATUS, 32'h0);
      chk("status", rd, {25'h0, rows[i].k, rows[i].m});
      chk("pins", {25'h0, k_factor, chip_mode}, {25'h0, rows[i].k, rows[i].m});
    end
    // slowdown divider at both ends of its range, pll divided by ten
    apb(1'h1, rbcg_pkg::OFF_CLOCK, 32'h1e3);
    cnt_en(32);
    chk("div 4", n, 8);
    chk("slow flag", {31'h0, slowdown_active}, 32'h1);
    apb(1'h1, rbcg_pkg::OFF_CLOCK, 32'h1ff);
    cnt_en(64);
    chk("div 32", n, 2);
    apb(1'h1, rbcg_pkg::OFF_CLOCK, 32'h1e0);
    cnt_en(32);
    chk("div 1", n, 32);
    apb(1'h1, rbcg_pkg::OFF_CLOCK, 32'h1df);
    cnt_en(32);
    chk("pll clock", {slowdown_active, n[30:0]}, 32);
    chk("k ten", {27'h0, k_factor}, 32'ha);
    // brownout: short dip ignored, long dip resets
    apb(1'h1, rbcg_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'h0, rbcg_pkg::OFF_IRQ_STAT, 32'h0);
    cmd_dip <= 1'h1;
    repeat (4) @(posedge pclk);
    cmd_dip <= 1'h0;
    repeat (3) @(negedge pclk);
    chk("short dip", {core_reset_n, port_tristate, irq}, 32'h4);
    @(posedge pclk);
    cmd_dip <= 1'h1;
    repeat (20) @(negedge pclk);
    chk("long dip", {core_reset_n, port_tristate, irq}, 32'h3);
    @(posedge pclk);
    apb(1'h0, rbcg_pkg::OFF_WAKEUP, 32'h0);
    chk("brownout flag", rd, 32'h3);
    apb(1'h0, rbcg_pkg::OFF_IRQ_STAT, 32'h0);
    chk("irq stat", {31'h0, rd[0]}, 32'h1);
    apb(1'h0, rbcg_pkg::OFF_IRQ_STAT, 32'h0);
    chk("irq cleared", {30'h0, rd[0], irq}, 32'h0);
    cmd_dip <= 1'h0;
    for (n = 0; n < 40 && core_reset_n !== 1'h1; n++)
      @(negedge pclk);
    chk("release wait", {core_reset_n, port_tristate, 1'h0, n >= 16 && n <= 24}, 32'h9);
    @(posedge pclk);
    apb(1'h1, rbcg_pkg::OFF_WAKEUP, 32'h0);
    cmd_dip <= 1'h1;
    repeat (20) @(posedge pclk);
    cmd_dip <= 1'h0;
    apb(1'h0, rbcg_pkg::OFF_WAKEUP, 32'h0);
    chk("flag off", rd, 32'h0);
    // software mode entry, then a pin reset in mid-unlock
    foreach (sw[i])
    begin
      unlock(sw[i][3:2]);
      chk("sw mode", {30'h0, chip_mode}, {30'h0, sw[i][1:0]});
    end
    apb(1'h0, rbcg_pkg::OFF_IRQ_STAT, 32'h0);
    chk("sw irq", rd, 32'h2);
    apb(1'h1, rbcg_pkg::OFF_SYSCTL1, 32'h2);
    apb(1'h1, rbcg_pkg::OFF_UNLOCK, {24'h0, rbcg_pkg::UNLOCK_KEY1});
    pin_reset(1'h1, 1'h0);
    apb(1'h1, rbcg_pkg::OFF_UNLOCK, {24'h0, rbcg_pkg::UNLOCK_KEY2});
    repeat (2) @(posedge pclk);
    chk("aborted", {30'h0, chip_mode}, 32'h0);
    apb(1'h0, rbcg_pkg::OFF_IRQ_STAT, 32'h0);
    chk("abort irq", rd, 32'h4);
    presetn <= 1'h0;
    @(negedge pclk);
    chk("reset again", {core_reset_n, port_tristate, chip_mode, k_factor, irq}, 32'h4);
    conclude();
  end
endmodule : rbcg_top_tb
